/* File: cmgpc_pkg.sv */
// Function
// - a current at the peak limit turns the switch off for the period.
// - the peak limit threshold is a software-writable converter code.
// - the soft-start pulse unit output is an extra falling-event source.
// - the first enabled falling-event source in a period ends the on-time.
// - the duty-limit pulse unit, width set by software, ends the on-time.
// - falling events are ignored during a programmed blanking interval.
// - a threshold crossing of the monitored signal flags the processor.
// - aux voltage, peak current or error may detect, alone or combined.
package cmgpc_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          CNT_W        = 16;
  localparam int          CODE_W       = 10;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_PERIOD   = 8'h04;
  localparam logic [7:0]  OFS_BLANK    = 8'h08;
  localparam logic [7:0]  OFS_SS_WIDTH = 8'h0c;
  localparam logic [7:0]  OFS_MD_WIDTH = 8'h10;
  localparam logic [7:0]  OFS_ILIM     = 8'h14;
  localparam logic [7:0]  OFS_THR_AUX  = 8'h18;
  localparam logic [7:0]  OFS_THR_PK   = 8'h1c;
  localparam logic [7:0]  OFS_THR_FB   = 8'h20;
  localparam logic [7:0]  OFS_STATUS   = 8'h24;
  localparam logic [7:0]  OFS_MASK     = 8'h28;
  localparam logic [7:0]  OFS_STATE    = 8'h2c;
  // control field positions
  localparam int          CTRL_EN      = 0;
  localparam int          CTRL_SS_EN   = 1;
  localparam int          CTRL_MD_EN   = 2;
  localparam int          CTRL_ILIM_EN = 3;
  localparam int          CTRL_SC_AUX  = 4;
  localparam int          CTRL_SC_PK   = 5;
  localparam int          CTRL_SC_FB   = 6;
  localparam int          CTRL_SC_AND  = 7;
  localparam int          CTRL_W       = 8;
  // status / mask bit positions
  localparam int          ST_SC        = 0;
  localparam int          ST_ILIM      = 1;
  localparam int          ST_W         = 2;
  // reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] PERIOD_RST   = 16'h0190;
  localparam logic [15:0] BLANK_RST    = 16'h0004;
  localparam logic [15:0] SS_RST       = 16'h0020;
  localparam logic [15:0] MD_RST       = 16'h0140;
  localparam logic [9:0]  CODE_RST     = 10'h3ff;
  localparam logic [1:0]  MASK_RST     = 2'h0;
  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {GATE_OFF, GATE_BLANK, GATE_ON} cmgpc_gate_t;
endpackage

/* File: cmgpc_thr_cmp.sv */
`timescale 1ns/10ps
// registered digital comparator: high while value is at or above threshold
module cmgpc_thr_cmp #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // operands
  input  wire logic [W-1:0] i_value,
  input  wire logic [W-1:0] i_thresh,
  // result
  output logic              o_above
);
  initial begin
    if (W < 1 || W > 16) $error("cmgpc_thr_cmp: width out of range");
  end

  // one register stage keeps the compare off the gate timing path
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_above <= 1'b0;
    end else if (i_ce) begin
      o_above <= (i_value >= i_thresh);
    end
  end
endmodule

/* File: cmgpc_top.sv */
`timescale 1ns/10ps
module cmgpc_top
  import cmgpc_pkg::*;
#(
  parameter int P_CNT_W = cmgpc_pkg::CNT_W
) (
  // clock, reset, enable
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_ce,
  // axi4-lite write address and data
  input  wire logic                         i_s_awvalid,
  output logic                              o_s_awready,
  input  wire logic [cmgpc_pkg::ADDR_W-1:0] i_s_awaddr,
  input  wire logic                         i_s_wvalid,
  output logic                              o_s_wready,
  input  wire logic [cmgpc_pkg::DATA_W-1:0] i_s_wdata,
  input  wire logic [3:0]                   i_s_wstrb,
  // axi4-lite write response
  output logic                              o_s_bvalid,
  input  wire logic                         i_s_bready,
  output logic [1:0]                        o_s_bresp,
  // axi4-lite read
  input  wire logic                         i_s_arvalid,
  output logic                              o_s_arready,
  input  wire logic [cmgpc_pkg::ADDR_W-1:0] i_s_araddr,
  output logic                              o_s_rvalid,
  input  wire logic                         i_s_rready,
  output logic [cmgpc_pkg::DATA_W-1:0]      o_s_rdata,
  output logic [1:0]                        o_s_rresp,
  // sensed signals
  input  wire logic                         i_fb_trip,
  input  wire logic [cmgpc_pkg::CODE_W-1:0] i_isense,
  input  wire logic [cmgpc_pkg::CODE_W-1:0] i_aux_v,
  input  wire logic [cmgpc_pkg::CODE_W-1:0] i_fb_err,
  // switch drive and processor flags
  output logic                              o_gate,
  output logic                              o_sc_fault,
  output logic                              o_irq
);
  import cmgpc_pkg::*;

  initial begin
    if (P_CNT_W < 4 || P_CNT_W > 16) $error("cmgpc_top: P_CNT_W range");
  end

  logic [CTRL_W-1:0]  ctrl_q;
  logic [P_CNT_W-1:0] period_q, blank_q, ss_q, md_q, cnt_q;
  logic [CODE_W-1:0]  ilim_q, thr_aux_q, thr_pk_q, thr_fb_q;
  logic [ST_W-1:0]    status_q, status_d, mask_q, st_set, st_clr;
  logic               awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic               aw_hold_q, w_hold_q, wr_go;
  logic [ADDR_W-1:0]  awaddr_q;
  logic [DATA_W-1:0]  wdata_q, rdata_q, rd_data, wr_val;
  logic [3:0]         wstrb_q;
  logic [1:0]         bresp_q, rresp_q;
  logic               rd_err, wr_err;
  logic               ilim_hit, sc_aux, sc_pk, sc_fb, sc_lvl, sc_prev_q;
  logic               gate_q, irq_q, fall, rise;
  logic [2:0]         sc_sel, sc_src;
  cmgpc_gate_t        state_q;

  // byte-lane merge of a write onto the supplied old value (zero at its one use)
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] dat, input logic [3:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = dat[8*b +: 8];
    end
    return r;
  endfunction

  // count has reached a programmed limit
  function automatic logic reached(input logic [P_CNT_W-1:0] c,
      input logic [P_CNT_W-1:0] lim);
    return c >= lim;
  endfunction

  // peak limit and short-circuit threshold comparators
  cmgpc_thr_cmp #(.W(CODE_W)) u_ilim (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_value(i_isense), .i_thresh(ilim_q), .o_above(ilim_hit));
  cmgpc_thr_cmp #(.W(CODE_W)) u_aux (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_value(i_aux_v), .i_thresh(thr_aux_q), .o_above(sc_aux));
  cmgpc_thr_cmp #(.W(CODE_W)) u_pk (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_value(i_isense), .i_thresh(thr_pk_q), .o_above(sc_pk));
  cmgpc_thr_cmp #(.W(CODE_W)) u_fb (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_value(i_fb_err), .i_thresh(thr_fb_q), .o_above(sc_fb));

  // write address and data are taken independently, one write at a time
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else if (i_ce) begin
      if (awready_q && i_s_awvalid) begin
        awready_q <= 1'b0;
        aw_hold_q <= 1'b1;
        awaddr_q  <= i_s_awaddr;
      end
      if (wready_q && i_s_wvalid) begin
        wready_q <= 1'b0;
        w_hold_q <= 1'b1;
        wdata_q  <= i_s_wdata;
        wstrb_q  <= i_s_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && i_s_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // unmapped write addresses and the read-only state word answer slverr
  always_comb begin
    wr_err = !(awaddr_q <= OFS_MASK && awaddr_q[1:0] == 2'h0);
  end

  // software-written configuration
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q    <= CTRL_RST;
      period_q  <= P_CNT_W'(PERIOD_RST);
      blank_q   <= P_CNT_W'(BLANK_RST);
      ss_q      <= P_CNT_W'(SS_RST);
      md_q      <= P_CNT_W'(MD_RST);
      ilim_q    <= CODE_RST;
      thr_aux_q <= CODE_RST;
      thr_pk_q  <= CODE_RST;
      thr_fb_q  <= CODE_RST;
      mask_q    <= MASK_RST;
    end else if (i_ce && wr_go) begin
      if (awaddr_q == OFS_CTRL) begin
        ctrl_q <= wr_val[CTRL_W-1:0];
      end else if (awaddr_q == OFS_PERIOD) begin
        period_q <= wr_val[P_CNT_W-1:0];
      end else if (awaddr_q == OFS_BLANK) begin
        blank_q <= wr_val[P_CNT_W-1:0];
      end else if (awaddr_q == OFS_SS_WIDTH) begin
        ss_q <= wr_val[P_CNT_W-1:0];
      end else if (awaddr_q == OFS_MD_WIDTH) begin
        md_q <= wr_val[P_CNT_W-1:0];
      end else if (awaddr_q == OFS_ILIM) begin
        ilim_q <= wr_val[CODE_W-1:0];
      end else if (awaddr_q == OFS_THR_AUX) begin
        thr_aux_q <= wr_val[CODE_W-1:0];
      end else if (awaddr_q == OFS_THR_PK) begin
        thr_pk_q <= wr_val[CODE_W-1:0];
      end else if (awaddr_q == OFS_THR_FB) begin
        thr_fb_q <= wr_val[CODE_W-1:0];
      end else if (awaddr_q == OFS_MASK) begin
        mask_q <= wr_val[ST_W-1:0];
      end
    end
  end

  // merge against zero: only written lanes carry meaning
  assign wr_val = merge('0, wdata_q, wstrb_q);

  // read path answers one cycle after the address is taken
  always_comb begin
    rd_err  = 1'b0;
    rd_data = '0;
    if (i_s_araddr == OFS_CTRL) begin
      rd_data = DATA_W'(ctrl_q);
    end else if (i_s_araddr == OFS_PERIOD) begin
      rd_data = DATA_W'(period_q);
    end else if (i_s_araddr == OFS_BLANK) begin
      rd_data = DATA_W'(blank_q);
    end else if (i_s_araddr == OFS_SS_WIDTH) begin
      rd_data = DATA_W'(ss_q);
    end else if (i_s_araddr == OFS_MD_WIDTH) begin
      rd_data = DATA_W'(md_q);
    end else if (i_s_araddr == OFS_ILIM) begin
      rd_data = DATA_W'(ilim_q);
    end else if (i_s_araddr == OFS_THR_AUX) begin
      rd_data = DATA_W'(thr_aux_q);
    end else if (i_s_araddr == OFS_THR_PK) begin
      rd_data = DATA_W'(thr_pk_q);
    end else if (i_s_araddr == OFS_THR_FB) begin
      rd_data = DATA_W'(thr_fb_q);
    end else if (i_s_araddr == OFS_STATUS) begin
      rd_data = DATA_W'(status_q);
    end else if (i_s_araddr == OFS_MASK) begin
      rd_data = DATA_W'(mask_q);
    end else if (i_s_araddr == OFS_STATE) begin
      rd_data = {6'h00, sc_lvl, ilim_hit, 2'(state_q), gate_q,
                 5'h00, 16'(cnt_q)};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (i_ce) begin
      if (arready_q && i_s_arvalid) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_data;
        rresp_q   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_q && i_s_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // short-circuit sources, alone (or) or all selected together (and)
  assign sc_sel = {ctrl_q[CTRL_SC_FB], ctrl_q[CTRL_SC_PK],
                   ctrl_q[CTRL_SC_AUX]};
  assign sc_src = {sc_fb, sc_pk, sc_aux} & sc_sel;
  assign sc_lvl = ctrl_q[CTRL_SC_AND] ? (sc_sel != 3'h0 && sc_src == sc_sel)
                                      : (sc_src != 3'h0);

  // the crossing is caught as a rising edge of the detector level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sc_prev_q <= 1'b0;
    end else if (i_ce) begin
      sc_prev_q <= sc_lvl;
    end
  end

  // sticky status: a new event wins over a write-one-to-clear
  always_comb begin
    st_set          = '0;
    st_set[ST_SC]   = sc_lvl && !sc_prev_q;
    st_set[ST_ILIM] = (state_q == GATE_ON) && ctrl_q[CTRL_ILIM_EN]
                      && ilim_hit;
    st_clr = (wr_go && awaddr_q == OFS_STATUS) ? wr_val[ST_W-1:0] : '0;
    status_d = (status_q & ~st_clr) | st_set;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else if (i_ce) begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
    end
  end

  // falling events: regulation, peak limit, soft-start, duty limit
  assign fall = i_fb_trip
              || (ctrl_q[CTRL_ILIM_EN] && ilim_hit)
              || (ctrl_q[CTRL_SS_EN] && reached(cnt_q, ss_q))
              || (ctrl_q[CTRL_MD_EN] && reached(cnt_q, md_q));
  // at-or-above: a period cut below the running count wraps at once
  assign rise = ctrl_q[CTRL_EN] && reached(cnt_q, period_q - 1'b1);

  // fixed-frequency timebase; counts only while the generator runs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      if (!ctrl_q[CTRL_EN] || rise) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // gate waveform generator; off holds until the next rising event
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= GATE_OFF;
      gate_q  <= 1'b0;
    end else if (i_ce) begin
      if (!ctrl_q[CTRL_EN]) begin
        state_q <= GATE_OFF;
        gate_q  <= 1'b0;
      end else if (rise) begin
        state_q <= GATE_BLANK;
        gate_q  <= 1'b1;
      end else begin
        case (state_q)
          GATE_BLANK: begin
            // events are masked here, which also sets the least on-time
            if (reached(cnt_q, blank_q)) state_q <= GATE_ON;
          end
          GATE_ON: begin
            if (fall) begin
              state_q <= GATE_OFF;
              gate_q  <= 1'b0;
            end
          end
          default: begin
            state_q <= GATE_OFF;
          end
        endcase
      end
    end
  end

  // outputs straight from flip-flops
  assign o_s_awready = awready_q;
  assign o_s_wready  = wready_q;
  assign o_s_bvalid  = bvalid_q;
  assign o_s_bresp   = bresp_q;
  assign o_s_arready = arready_q;
  assign o_s_rvalid  = rvalid_q;
  assign o_s_rdata   = rdata_q;
  assign o_s_rresp   = rresp_q;
  assign o_gate      = gate_q;
  assign o_sc_fault  = status_q[ST_SC];
  assign o_irq       = irq_q;
endmodule

/* File: cmgpc_chk.sv */
`timescale 1ns/10ps
// port-level checks on the bus handshake and the gate timing
module cmgpc_chk
  import cmgpc_pkg::*;
(
  // clock and reset
  input wire logic                         i_clk,
  input wire logic                         i_rst,
  // register bus
  input wire logic                         i_s_awvalid,
  input wire logic                         o_s_awready,
  input wire logic [cmgpc_pkg::ADDR_W-1:0] i_s_awaddr,
  input wire logic                         i_s_wvalid,
  input wire logic                         o_s_wready,
  input wire logic                         o_s_bvalid,
  input wire logic                         i_s_bready,
  input wire logic [1:0]                   o_s_bresp,
  input wire logic                         i_s_arvalid,
  input wire logic                         o_s_arready,
  input wire logic                         o_s_rvalid,
  input wire logic                         i_s_rready,
  input wire logic [cmgpc_pkg::DATA_W-1:0] o_s_rdata,
  // gate side
  input wire logic                         i_fb_trip,
  input wire logic                         o_gate,
  input wire logic                         o_sc_fault
);
  logic       bad_q;  // accepted write address is refused
  logic [3:0] trip_q; // cycles of gate on while a trip stands

  // remember the kind of the last accepted write address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) bad_q <= 1'b0;
    else if (i_s_awvalid && o_s_awready)
      bad_q <= (i_s_awaddr >= OFS_STATE) || (i_s_awaddr[1:0] != 2'h0);
  end
  // saturates so a stuck gate cannot wrap back into the legal range
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) trip_q <= 4'h0;
    else if (!(o_gate && i_fb_trip)) trip_q <= 4'h0;
    else if (trip_q != 4'hf) trip_q <= trip_q + 4'h1;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_wr_ans;
    i_s_awvalid && o_s_awready && i_s_wvalid && o_s_wready |-> ##2 o_s_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_aw_ret;
    o_s_bvalid && i_s_bready |=> !o_s_bvalid ##1 o_s_awready && o_s_wready;
  endproperty
  a_aw_ret: assert property (p_aw_ret) else $error("write ready not back");
  property p_rd_ans;
    i_s_arvalid && o_s_arready |=> o_s_rvalid && !o_s_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold;
    o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_resp;
    o_s_bvalid |-> o_s_bresp == (bad_q ? RESP_SLVERR : RESP_OKAY);
  endproperty
  a_resp: assert property (p_resp) else $error("write response wrong");
  property p_min_on;
    $rose(o_gate) |-> o_gate [*2];
  endproperty
  a_min_on: assert property (p_min_on) else $error("on-time too short");
  property p_trip;
    trip_q <= 4'ha;
  endproperty
  a_trip: assert property (p_trip) else $error("trip ignored");
  property p_clr;
    $fell(o_sc_fault) |-> $rose(o_s_bvalid);
  endproperty
  a_clr: assert property (p_clr) else $error("fault lost");
endmodule

bind cmgpc_top cmgpc_chk cmgpc_chk_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_s_awvalid(i_s_awvalid), .o_s_awready(o_s_awready),
  .i_s_awaddr(i_s_awaddr), .i_s_wvalid(i_s_wvalid), .o_s_wready(o_s_wready),
  .o_s_bvalid(o_s_bvalid), .i_s_bready(i_s_bready), .o_s_bresp(o_s_bresp),
  .i_s_arvalid(i_s_arvalid), .o_s_arready(o_s_arready),
  .o_s_rvalid(o_s_rvalid), .i_s_rready(i_s_rready), .o_s_rdata(o_s_rdata),
  .i_fb_trip(i_fb_trip), .o_gate(o_gate), .o_sc_fault(o_sc_fault));

/* File: cmgpc_plant.sv */
`timescale 1ns/10ps
// switch and sense network: current ramps while the switch is on
module cmgpc_plant
  import cmgpc_pkg::*;
#(
  parameter int SLOPE = 8
) (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // switch drive in, sensed current out
  input  wire logic                         i_gate,
  output logic [cmgpc_pkg::CODE_W-1:0]      o_isense
);
  // inductor current collapses at turn-off; clipped at full scale
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_isense <= 10'h000;
    else if (!i_gate) o_isense <= 10'h000;
    else if (o_isense > 10'(1023 - SLOPE)) o_isense <= 10'h3ff;
    else o_isense <= o_isense + 10'(SLOPE);
  end
endmodule

/* File: tb_current_mode_gate_pulse_control.sv */
`timescale 1ns/10ps
module tb_current_mode_gate_pulse_control;
  import cmgpc_pkg::*;
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_fb_trip = 0;
  logic i_s_awvalid = 0, i_s_wvalid = 0, i_s_bready = 0;
  logic i_s_arvalid = 0, i_s_rready = 0;
  logic [7:0] i_s_awaddr = 8'h00, i_s_araddr = 8'h00;
  logic [31:0] i_s_wdata = 32'h0, d, m [0:10], wm [0:10];
  logic [9:0] i_isense, i_aux_v = 10'h000, i_fb_err = 10'h000;
  logic o_s_awready, o_s_wready, o_s_bvalid, o_s_arready, o_s_rvalid;
  logic [1:0] o_s_bresp, o_s_rresp;
  logic [31:0] o_s_rdata;
  logic o_gate, o_sc_fault, o_irq;
  int errors = 0, check_count = 0, seed = 15, wd, i, k, on, per, b, s, md;

  always #12.5 i_clk = ~i_clk;

  cmgpc_top cmgpc_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_s_awvalid(i_s_awvalid), .o_s_awready(o_s_awready),
    .i_s_awaddr(i_s_awaddr), .i_s_wvalid(i_s_wvalid),
    .o_s_wready(o_s_wready), .i_s_wdata(i_s_wdata), .i_s_wstrb(4'hf),
    .o_s_bvalid(o_s_bvalid), .i_s_bready(i_s_bready), .o_s_bresp(o_s_bresp),
    .i_s_arvalid(i_s_arvalid), .o_s_arready(o_s_arready),
    .i_s_araddr(i_s_araddr), .o_s_rvalid(o_s_rvalid),
    .i_s_rready(i_s_rready), .o_s_rdata(o_s_rdata), .o_s_rresp(o_s_rresp),
    .i_fb_trip(i_fb_trip), .i_isense(i_isense), .i_aux_v(i_aux_v),
    .i_fb_err(i_fb_err), .o_gate(o_gate), .o_sc_fault(o_sc_fault),
    .o_irq(o_irq));
  cmgpc_plant #(.SLOPE(8)) cmgpc_plant_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_gate(o_gate), .o_isense(i_isense));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // each wait but the reset hold and the single edge opening wr and rd steps through here so a hang ends the run
  task tick();
    @(posedge i_clk);
    wd++;
    if (wd > 3000) begin
      errors++;
      final_report();
    end
  endtask
  task wait_n(input int n);
    wd = 0;
    repeat (n) tick();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw;
    ta = 0;
    tw = 0;
    wd = 0;
    @(posedge i_clk);
    i_s_awvalid <= 1; i_s_awaddr <= a; i_s_wvalid <= 1; i_s_wdata <= v;
    i_s_bready <= 1;
    while (!(ta && tw)) begin
      tick();
      if (!ta && o_s_awready === 1'b1) begin ta = 1; i_s_awvalid <= 0; end
      if (!tw && o_s_wready === 1'b1) begin tw = 1; i_s_wvalid <= 0; end
    end
    do tick(); while (o_s_bvalid !== 1'b1);
    i_s_bready <= 0;
    check({30'h0, o_s_bresp}, {30'h0, er});
    if (er === RESP_OKAY && a != OFS_STATUS) m[a>>2] = v & wm[a>>2];
  endtask
  // ready comes one cycle late so the answer must stand
  task rd(input logic [7:0] a, input logic [1:0] er);
    wd = 0;
    @(posedge i_clk);
    i_s_arvalid <= 1; i_s_araddr <= a;
    do tick(); while (o_s_arready !== 1'b1);
    i_s_arvalid <= 0;
    tick();
    i_s_rready <= 1;
    do tick(); while (o_s_rvalid !== 1'b1);
    i_s_rready <= 0;
    d = o_s_rdata;
    check({30'h0, o_s_rresp}, {30'h0, er});
  endtask
  task meas();
    wd = 0;
    while (o_gate !== 1'b0) tick();
    while (o_gate !== 1'b1) tick();
    on = 0;
    while (o_gate === 1'b1) begin on++; tick(); end
    per = on;
    while (o_gate === 1'b0) begin per++; tick(); end
  endtask
  // first period after a change is skipped, the second one is judged
  task cfg(input logic [7:0] c, input int bl, input int ss, input int mw);
    wr(OFS_CTRL, c, RESP_OKAY); wr(OFS_BLANK, bl, RESP_OKAY);
    wr(OFS_SS_WIDTH, ss, RESP_OKAY); wr(OFS_MD_WIDTH, mw, RESP_OKAY);
    meas(); meas();
  endtask
  function int exp_on(int bl, int ss, int mw, bit se);
    int t;
    t = (se && ss < mw) ? ss : mw;
    return (t + 1 < bl + 2) ? bl + 2 : t + 1;
  endfunction

  initial begin
    m = '{32'(CTRL_RST), 32'(PERIOD_RST), 32'(BLANK_RST), 32'(SS_RST),
          32'(MD_RST), 32'(CODE_RST), 32'(CODE_RST), 32'(CODE_RST),
          32'(CODE_RST), 0, 32'(MASK_RST)};
    wm = '{32'hff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'h3ff,
           32'h3ff, 32'h3ff, 32'h3ff, 0, 32'h3};
    repeat (20) @(posedge i_clk);
    i_rst <= 0;
    // reset values, then refused places
    for (i = 0; i < 11; i++) begin
      rd(8'(i * 4), RESP_OKAY);
      check(d, m[i]);
    end
    rd(8'h30, RESP_SLVERR); check(d, 32'h0);
    wr(OFS_STATE, 32'hffff, RESP_SLVERR);
    wr(8'h01, 32'h1, RESP_SLVERR);
    // random contents read back through the field widths
    for (i = 0; i < 11; i++) if (i != 9) begin
      d = $random(seed);
      if (i == 0) d[0] = 1'b1;
      if (i == 1) d[8] = 1'b1;
      wr(8'(i * 4), d, RESP_OKAY);
    end
    for (i = 0; i < 11; i++) if (i != 9) begin
      rd(8'(i * 4), RESP_OKAY); check(d, m[i]);
    end
    // duty limit and soft-start as falling sources
    wr(OFS_PERIOD, 40, RESP_OKAY);
    wr(OFS_MASK, 0, RESP_OKAY);
    for (k = 0; k < 6; k++) begin
      b = {$random(seed)} % 8;
      s = 3 + {$random(seed)} % 28;
      md = 3 + {$random(seed)} % 28;
      cfg(8'h05 | 8'(k % 2 * 2), b, s, md);
      check(on, exp_on(b, s, md, k % 2));
      check(per, 40);
    end
    // a standing regulation trip is held off only by the blanking
    i_fb_trip <= 1;
    cfg(8'h05, 6, 20, 30);
    check(on, 8);
    i_fb_trip <= 0;
    // limit code from 2 ohm, 30 W, 90 V, 5 V supply, 1024 codes
    k = (2000 * 30 * 1024) / (90 * 5000);
    wr(OFS_ILIM, k, RESP_OKAY);
    cfg(8'h0d, 2, 20, 30);
    check(on, (k + 7) / 8 + 2);
    rd(OFS_STATUS, RESP_OKAY); check(d & 32'h2, 32'h2);
    wr(OFS_ILIM, 64, RESP_OKAY);
    meas(); meas();
    check(on, 10);
    // each short-circuit source on its own
    wr(OFS_ILIM, 32'h3ff, RESP_OKAY);
    for (i = 0; i < 3; i++) wr(8'(OFS_THR_AUX + i * 4), 100, RESP_OKAY);
    wr(OFS_STATUS, 3, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      i_aux_v <= (i == 0) ? 10'd200 : 10'd0;
      i_fb_err <= (i == 2) ? 10'd200 : 10'd0;
      wr(OFS_CTRL, 8'h05 | (8'h10 << i), RESP_OKAY);
      wait_n(50);
      check(o_sc_fault, 1);
      if (i == 0) begin
        check(o_irq, 0);
        wr(OFS_MASK, 1, RESP_OKAY);
        wait_n(3);
        check(o_irq, 1);
      end
      i_aux_v <= 0;
      i_fb_err <= 0;
      wr(OFS_CTRL, 8'h05, RESP_OKAY);
      wr(OFS_STATUS, 3, RESP_OKAY);
      check(o_sc_fault, 0);
      wait_n(3);
      check(o_irq, 0);
    end
    // combined detection needs both selected sources
    i_aux_v <= 10'd200;
    wr(OFS_CTRL, 8'hd5, RESP_OKAY);
    wait_n(20);
    check(o_sc_fault, 0);
    i_fb_err <= 10'd200;
    wait_n(20);
    check(o_sc_fault, 1);
    // a low enable freezes the gate for longer than one period
    i_ce <= 0;
    tick();
    b = o_gate;
    wait_n(45);
    check(o_gate, b);
    i_ce <= 1;
    final_report();
  end
endmodule
